// ===== rtl/power_monitor_alert_flags.sv
// diagnostic and alert flag logic of a power monitor
// assumes register strobes are one-cycle pulses from the serial front end,
// and converter strobes are one-cycle pulses on clock_i
`timescale 1ns/10ps
module power_monitor_alert_flags
  import pwr_alert_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [5:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [15:0]      reg_rdata_o,
  // converter side
  input  wire logic        raw_valid_i,
  input  wire logic        avg_valid_i,
  input  wire logic        conv_done_i,
  input  wire logic        conv_trigger_i,
  input  wire logic        arith_overflow_i,
  input  wire logic        trim_error_i,
  input  wire logic [15:0] shunt_value_i,
  input  wire logic [15:0] bus_value_i,
  input  wire logic [11:0] temp_value_i,
  input  wire logic [23:0] power_value_i,
  // thresholds kept outside this block
  input  wire logic [14:0] bus_high_limit_i,
  input  wire logic [14:0] bus_low_limit_i,
  input  wire logic [11:0] temp_high_limit_i,
  input  wire logic [15:0] power_limit_i,
  // status out
  output logic             shunt_range_select_o,
  output logic             alert_o,
  output logic             alert_oe_o
);

  // ***********************
  // state
  // ***********************
  typedef struct packed {
    logic [15:0] shunt_high_threshold;
    logic [15:0] shunt_low_threshold;
    logic [3:0]  ctrl;
    logic        arith_overflow_flag;
    logic        conversion_done_flag;
    logic        trim_checksum_ok;
    logic [15:0] rdata;
    logic        alert_level;
    logic        drive;
    logic        range_select;
  } top_state_s;

  top_state_s st_r;
  top_state_s st_nxt;

  logic alert_latch_select;
  logic done_alert_enable;
  logic averaged_compare_select;
  logic alert_sense_invert;
  logic sample;
  logic diag_read;
  logic [5:0]  limit_flags;
  logic [15:0] diag_word;
  logic        alert_active;

  assign alert_latch_select      = st_r.ctrl[3];
  assign done_alert_enable       = st_r.ctrl[2];
  assign averaged_compare_select = st_r.ctrl[1];
  assign alert_sense_invert      = st_r.ctrl[0];
  assign diag_read               = reg_rd_i && (reg_addr_i == ADDR_DIAG);

  // RULE_01 raw or averaged
  assign sample = averaged_compare_select ? avg_valid_i : raw_valid_i;

  // ***********************
  // comparators
  // ***********************
  // RULE_05 temperature over
  limit_compare #(.WIDTH(12), .SIGNED(1'b1), .OVER(1'b1)) u_temp_ov (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .sample_i (sample),
    .value_i  (temp_value_i),
    .limit_i  (temp_high_limit_i),
    .latch_i  (alert_latch_select),
    .clear_i  (diag_read),
    .flag_o   (limit_flags[5])
  );

  // RULE_06 RULE_15 signed shunt over
  limit_compare #(.WIDTH(16), .SIGNED(1'b1), .OVER(1'b1)) u_shunt_ov (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .sample_i (sample),
    .value_i  (shunt_value_i),
    .limit_i  (st_r.shunt_high_threshold),
    .latch_i  (alert_latch_select),
    .clear_i  (diag_read),
    .flag_o   (limit_flags[4])
  );

  // RULE_07 shunt under
  limit_compare #(.WIDTH(16), .SIGNED(1'b1), .OVER(1'b0)) u_shunt_un (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .sample_i (sample),
    .value_i  (shunt_value_i),
    .limit_i  (st_r.shunt_low_threshold),
    .latch_i  (alert_latch_select),
    .clear_i  (diag_read),
    .flag_o   (limit_flags[3])
  );

  // RULE_08 bus over
  limit_compare #(.WIDTH(16), .SIGNED(1'b0), .OVER(1'b1)) u_bus_ov (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .sample_i (sample),
    .value_i  (bus_value_i),
    .limit_i  ({1'b0, bus_high_limit_i}),
    .latch_i  (alert_latch_select),
    .clear_i  (diag_read),
    .flag_o   (limit_flags[2])
  );

  // RULE_09 bus under
  limit_compare #(.WIDTH(16), .SIGNED(1'b0), .OVER(1'b0)) u_bus_un (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .sample_i (sample),
    .value_i  (bus_value_i),
    .limit_i  ({1'b0, bus_low_limit_i}),
    .latch_i  (alert_latch_select),
    .clear_i  (diag_read),
    .flag_o   (limit_flags[1])
  );

  // RULE_10 power over, limit in units of 256 power steps
  limit_compare #(.WIDTH(24), .SIGNED(1'b0), .OVER(1'b1)) u_pwr_ov (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .sample_i (sample),
    .value_i  (power_value_i),
    .limit_i  ({power_limit_i, 8'hFF}),
    .latch_i  (alert_latch_select),
    .clear_i  (diag_read),
    .flag_o   (limit_flags[0])
  );

  // ***********************
  // diagnostic word
  // ***********************
  // RULE_03 reserved zero
  always_comb
  begin
    diag_word                = 16'h0000;
    diag_word[15:12]         = st_r.ctrl;
    diag_word[BIT_ARITH_OF]  = st_r.arith_overflow_flag;
    diag_word[7:2]           = limit_flags;
    diag_word[BIT_DONE]      = st_r.conversion_done_flag;
    diag_word[BIT_TRIM_OK]   = st_r.trim_checksum_ok;
  end

  // RULE_21 RULE_22 alert source
  assign alert_active = (|limit_flags) || (done_alert_enable && st_r.conversion_done_flag);

  always_comb
  begin
    st_nxt = st_r;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        ADDR_DIAG:       st_nxt.ctrl = reg_wdata_i[15:12];
        // RULE_17 RULE_19 full 16 bits, same scale as shunt result
        ADDR_SHUNT_HIGH: st_nxt.shunt_high_threshold = reg_wdata_i;
        // RULE_18 full 16 bits
        ADDR_SHUNT_LOW:  st_nxt.shunt_low_threshold = reg_wdata_i;
        default:         st_nxt.ctrl = st_r.ctrl;
      endcase
    end
    // RULE_04 clear on trigger, set wins
    if (conv_trigger_i)
      st_nxt.arith_overflow_flag = 1'b0;
    if (arith_overflow_i)
      st_nxt.arith_overflow_flag = 1'b1;
    // RULE_13 done clear paths
    if (alert_latch_select)
    begin
      if (diag_read || conv_trigger_i)
        st_nxt.conversion_done_flag = 1'b0;
    end
    else if (conv_trigger_i)
    begin
      // RULE_20 transparent idles on next trigger
      st_nxt.conversion_done_flag = 1'b0;
    end
    // RULE_12 done set
    if (conv_done_i)
      st_nxt.conversion_done_flag = 1'b1;
    // RULE_14 checksum status
    if (trim_error_i)
      st_nxt.trim_checksum_ok = 1'b0;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        ADDR_DIAG:       st_nxt.rdata = diag_word;
        ADDR_SHUNT_HIGH: st_nxt.rdata = st_r.shunt_high_threshold;
        ADDR_SHUNT_LOW:  st_nxt.rdata = st_r.shunt_low_threshold;
        default:         st_nxt.rdata = 16'h0000;
      endcase
    end
    // RULE_02 polarity, open drain
    st_nxt.drive        = alert_sense_invert ? ~alert_active : alert_active;
    // open drain only ever pulls low; the pin level lives in drive
    st_nxt.alert_level  = 1'b0;
    // range select belongs to the converter block, held cleared here
    st_nxt.range_select = 1'b0;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r.shunt_high_threshold <= SHUNT_HIGH_RST;
      st_r.shunt_low_threshold  <= SHUNT_LOW_RST;
      st_r.ctrl                 <= CTRL_RST;
      st_r.arith_overflow_flag  <= 1'b0;
      st_r.conversion_done_flag <= 1'b0;
      st_r.trim_checksum_ok     <= 1'b1;
      st_r.rdata                <= 16'h0000;
      st_r.alert_level          <= 1'b0;
      st_r.drive                <= 1'b0;
      st_r.range_select         <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o          = st_r.rdata;
  assign shunt_range_select_o = st_r.range_select;
  assign alert_o              = st_r.alert_level;
  assign alert_oe_o           = st_r.drive;

  // ***********************
  // checks
  // ***********************
  // RULE_04
  property p_overflow_set;
    @(posedge clock_i) disable iff (rst_i)
    arith_overflow_i |=> st_r.arith_overflow_flag;
  endproperty
  a_overflow_set: assert property (p_overflow_set) else $error("overflow flag not set"); // RULE_04

  property p_done_set;
    @(posedge clock_i) disable iff (rst_i)
    conv_done_i |=> diag_word[BIT_DONE];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set"); // RULE_12

  property p_done_clear;
    @(posedge clock_i) disable iff (rst_i)
    (alert_latch_select && diag_read && !conv_done_i) |=> !st_r.conversion_done_flag;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag not cleared"); // RULE_13

  property p_reserved;
    @(posedge clock_i) disable iff (rst_i)
    diag_read |=> (reg_rdata_o[11:10] == 2'b00) && !reg_rdata_o[8];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero"); // RULE_03

  property p_alert_drive;
    @(posedge clock_i) disable iff (rst_i)
    ##1 (alert_oe_o == ($past(alert_sense_invert) ^ $past(alert_active)));
  endproperty
  a_alert_drive: assert property (p_alert_drive) else $error("alert drive wrong"); // RULE_02

  property p_latch_hold;
    @(posedge clock_i) disable iff (rst_i)
    (alert_latch_select && limit_flags[4] && !diag_read && !reg_wr_i) |=> limit_flags[4];
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched flag dropped"); // RULE_11

  property p_shunt_over;
    @(posedge clock_i) disable iff (rst_i)
    (sample && ($signed(shunt_value_i) > $signed(st_r.shunt_high_threshold))) |=> limit_flags[4];
  endproperty
  a_shunt_over: assert property (p_shunt_over) else $error("shunt over missed"); // RULE_06

  property p_trim;
    @(posedge clock_i) disable iff (rst_i)
    trim_error_i |=> !st_r.trim_checksum_ok;
  endproperty
  a_trim: assert property (p_trim) else $error("trim status not cleared"); // RULE_14

  c_latched_read: cover property (@(posedge clock_i) disable iff (rst_i)
    alert_latch_select && limit_flags[4] ##1 diag_read);
  c_done_alert: cover property (@(posedge clock_i) disable iff (rst_i)
    done_alert_enable && conv_done_i);
  c_inverted: cover property (@(posedge clock_i) disable iff (rst_i)
    alert_sense_invert && alert_oe_o == 1'b0 && alert_active);

endmodule

// ===== rtl/pwr_alert_pkg.sv
// constants for the power monitor alert and diagnostic flag block
// assumes a register port with a word address, write strobe and read strobe
//
// Operation
// RULE_01 - slow-alert bit picks averaged results over raw results for comparing
// RULE_02 - polarity bit: alert active low when clear, active high when set
// RULE_03 - diagnostic bits 11-10 and bit 8 always read zero
// RULE_04 - overflow flag bit 9 sets on arithmetic overflow, clears on new trigger
// RULE_05 - bit 7 sets when temperature exceeds temperature over-limit
// RULE_06 - bit 6 sets when shunt result exceeds shunt over-limit threshold
// RULE_07 - bit 5 sets when shunt result falls below shunt under-limit threshold
// RULE_08 - bit 4 sets when bus result exceeds bus over-limit
// RULE_09 - bit 3 sets when bus result falls below bus under-limit
// RULE_10 - bit 2 sets when power result exceeds power limit
// RULE_11 - latched mode: limit flags 7..2 hold until diagnostic register read
// RULE_12 - bit 1 sets each time a conversion finishes
// RULE_13 - latched mode: done flag clears on diagnostic read or new trigger
// RULE_14 - trim status bit 0 resets to one, reads zero on checksum error
// RULE_15 - signed compare: negative over-limit makes zero shunt trip alarm
// RULE_16 - software sets over-limit above under-limit when both negative
// RULE_17 - shunt over-limit: 16-bit signed read/write, reset 7FFF
// RULE_18 - shunt under-limit: 16-bit signed read/write, reset 8000
// RULE_19 - shunt thresholds share the shunt result scaling set by range select
// RULE_20 - transparent mode follows fault; latched mode holds until read
// RULE_21 - done alert enable puts conversion-done onto the alert output
// RULE_22 - alert asserts on any limit flag, or done flag when enabled
// RULE_23 - over compares strictly greater, under strictly less, signed where signed
package pwr_alert_pkg;

  // ***********************
  // register map
  // ***********************
  localparam logic [5:0]  ADDR_DIAG       = 6'h0B;
  localparam logic [5:0]  ADDR_SHUNT_HIGH = 6'h0C;
  localparam logic [5:0]  ADDR_SHUNT_LOW  = 6'h0D;

  localparam logic [15:0] SHUNT_HIGH_RST  = 16'h7FFF;
  localparam logic [15:0] SHUNT_LOW_RST   = 16'h8000;

  // ***********************
  // diagnostic field positions
  // ***********************
  localparam int BIT_LATCH     = 15;
  localparam int BIT_DONE_EN   = 14;
  localparam int BIT_AVG_SEL   = 13;
  localparam int BIT_SENSE_INV = 12;
  localparam int BIT_ARITH_OF  = 9;
  localparam int BIT_TEMP_OV   = 7;
  localparam int BIT_SHUNT_OV  = 6;
  localparam int BIT_SHUNT_UN  = 5;
  localparam int BIT_BUS_OV    = 4;
  localparam int BIT_BUS_UN    = 3;
  localparam int BIT_PWR_OV    = 2;
  localparam int BIT_DONE      = 1;
  localparam int BIT_TRIM_OK   = 0;

  // control bits 15..12 are writable
  localparam logic [3:0]  CTRL_RST        = 4'h0;
  localparam logic [5:0]  LIMIT_FLAGS_RST = 6'h00;

endpackage

// ===== rtl/limit_compare.sv
// one limit comparator stage with flag hold
// assumes results and thresholds are already in matching scale
`timescale 1ns/10ps
module limit_compare
  import pwr_alert_pkg::*;
#(
  parameter int  WIDTH  = 16,
  parameter bit  SIGNED = 1'b1,
  parameter bit  OVER   = 1'b1
)(
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic             sample_i,
  input  wire logic [WIDTH-1:0] value_i,
  input  wire logic [WIDTH-1:0] limit_i,
  input  wire logic             latch_i,
  input  wire logic             clear_i,
  output logic                  flag_o
);

  typedef struct packed {
    logic flag;
  } cmp_state_s;

  cmp_state_s st_r;
  cmp_state_s st_nxt;
  logic       hit;

  // RULE_23 strict compare
  always_comb
  begin
    if (SIGNED)
    begin
      hit = OVER ? ($signed(value_i) > $signed(limit_i))
                 : ($signed(value_i) < $signed(limit_i));
    end
    else
    begin
      hit = OVER ? (value_i > limit_i) : (value_i < limit_i);
    end
  end

  // RULE_11 latched hold
  always_comb
  begin
    st_nxt = st_r;
    if (latch_i)
    begin
      // set beats a clear in the same cycle
      if (clear_i)
        st_nxt.flag = 1'b0;
      if (sample_i && hit)
        st_nxt.flag = 1'b1;
    end
    else if (sample_i)
    begin
      // RULE_20 transparent follow
      st_nxt.flag = hit;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign flag_o = st_r.flag;

endmodule

// ===== dv/reg_host.sv
// host side model: issues register writes and reads, notes expected read data
// assumes strobes are taken on the rising edge of clock_i
`timescale 1ns/10ps
module reg_host (
  input  wire logic   clock_i,
  output logic [5:0]  reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic        reg_wr_o,
  output logic        reg_rd_o
);
  logic [15:0] exp_q [$];

  initial
  begin
    reg_addr_o  = 6'h00;
    reg_wdata_o = 16'h0000;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end

  // released lines show inverted values, never the last ones
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clock_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge clock_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge clock_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge clock_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
  endtask
endmodule

// ===== dv/power_monitor_alert_flags_test.sv
// self-checking bench for the alert and diagnostic flag block
// assumes reg_host as register master; bench drives converter side
`timescale 1ns/10ps
module power_monitor_alert_flags_test;
  import pwr_alert_pkg::*;
  logic        clock_i, rst_i, rd_seen, inv;
  logic [5:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, shunt, bus, plim;
  logic        reg_wr, reg_rd, raw_v, avg_v, done, trig, ovf, trim_err;
  logic [11:0] temp, thi;
  logic [23:0] pwr;
  logic [14:0] bhi, blo;
  logic        range_sel, alert, alert_oe;
  logic [31:0] lfsr_r;
  int          num_errors = 0;
  int          checks = 0;
  localparam logic [15:0] T_BUS [9] = '{16'h0101, 16'h0100, 16'h000F, 16'h0010,
    16'h0050, 16'h0050, 16'h0050, 16'h0050, 16'h0050};
  localparam logic [11:0] T_TMP [9] = '{12'h000, 12'h000, 12'h000, 12'h000,
    12'h011, 12'hFF0, 12'h010, 12'h000, 12'h000};
  localparam logic [23:0] T_PWR [9] = '{24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0,
    24'h0, 24'h0001FF, 24'h000200};
  localparam logic [15:0] T_EXP [9] = '{16'h0011, 16'h0001, 16'h0009, 16'h0001,
    16'h0081, 16'h0001, 16'h0001, 16'h0001, 16'h0005};

  reg_host u_reg_host (
    .clock_i     (clock_i),
    .reg_addr_o  (reg_addr),
    .reg_wdata_o (reg_wdata),
    .reg_wr_o    (reg_wr),
    .reg_rd_o    (reg_rd)
  );

  power_monitor_alert_flags u_power_monitor_alert_flags (
    .clock_i (clock_i), .rst_i (rst_i), .reg_addr_i (reg_addr),
    .reg_wdata_i (reg_wdata), .reg_wr_i (reg_wr), .reg_rd_i (reg_rd),
    .reg_rdata_o (reg_rdata), .raw_valid_i (raw_v), .avg_valid_i (avg_v),
    .conv_done_i (done), .conv_trigger_i (trig), .arith_overflow_i (ovf),
    .trim_error_i (trim_err), .shunt_value_i (shunt), .bus_value_i (bus),
    .temp_value_i (temp), .power_value_i (pwr), .bus_high_limit_i (bhi),
    .bus_low_limit_i (blo), .temp_high_limit_i (thi), .power_limit_i (plim),
    .shunt_range_select_o (range_sel), .alert_o (alert), .alert_oe_o (alert_oe)
  );

  // ***********************
  // helpers
  // ***********************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cmp16(input string n, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cmp1(input string n, input logic e, input logic s);
    checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("BAD %s expected %b seen %b", n, e, s);
    end
  endtask

  // pin drive low when asserted active-low, released when asserted active-high
  task automatic ca(input logic a);
    repeat (3) @(posedge clock_i);
    #1;
    cmp1("alert_oe", a ^ inv, alert_oe);
    cmp1("alert", 1'b0, alert);
    cmp1("shunt_range_select", 1'b0, range_sel);
  endtask

  task automatic smp(input logic [15:0] s, input logic [15:0] b, input logic [11:0] t,
                     input logic [23:0] p, input logic avg);
    @(posedge clock_i);
    {shunt, bus, temp, pwr} <= {s, b, t, p};
    {raw_v, avg_v} <= {~avg, avg};
    @(posedge clock_i);
    {raw_v, avg_v} <= 2'h0;
    {shunt, bus, temp, pwr} <= ~{s, b, t, p};
  endtask

  task automatic pls(input int k);
    @(posedge clock_i);
    {done, trig, ovf} <= 3'h4 >> k;
    @(posedge clock_i);
    {done, trig, ovf} <= 3'h0;
  endtask

  task automatic wdiag(input logic [3:0] c);
    u_reg_host.wr(ADDR_DIAG, {c, 12'hD01});
  endtask

  task automatic end_sim();
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clock_i) rd_seen <= reg_rd;
  always @(negedge clock_i)
    if (rd_seen === 1'b1)
      cmp16("reg_rdata", u_reg_host.exp_q.pop_front(), reg_rdata);

  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  initial
  begin
    #200000;
    num_errors++;
    end_sim();
  end

  // ***********************
  // main sequence
  // ***********************
  initial
  begin
    rst_i = 1'b1;
    {raw_v, avg_v, done, trig, ovf, trim_err, inv} = 7'h00;
    {shunt, bus, temp, pwr} = 68'h0;
    {bhi, blo, thi, plim} = {15'h7FFF, 15'h0000, 12'h7FF, 16'hFFFF};
    lfsr_r = 32'h2961FC47;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    u_reg_host.rd(ADDR_SHUNT_HIGH, SHUNT_HIGH_RST);
    u_reg_host.rd(ADDR_SHUNT_LOW, SHUNT_LOW_RST);
    u_reg_host.rd(ADDR_DIAG, 16'h0001);
    u_reg_host.rd(6'h00, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      u_reg_host.wr(ADDR_SHUNT_HIGH, lfsr_r[15:0]);
      u_reg_host.wr(ADDR_SHUNT_LOW, lfsr_r[31:16]);
      u_reg_host.rd(ADDR_SHUNT_HIGH, lfsr_r[15:0]);
      u_reg_host.rd(ADDR_SHUNT_LOW, lfsr_r[31:16]);
    end
    wdiag(4'h0);
    u_reg_host.rd(ADDR_DIAG, 16'h0001);
    // over-limit kept above under-limit when both negative
    u_reg_host.wr(ADDR_SHUNT_HIGH, 16'hFFFB);
    u_reg_host.wr(ADDR_SHUNT_LOW, 16'hFFF0);
    smp(16'h0000, 16'h0050, 12'h000, 24'h0, 1'b0);
    u_reg_host.rd(ADDR_DIAG, 16'h0041);
    ca(1'b1);
    smp(16'hFFFB, 16'h0050, 12'h000, 24'h0, 1'b0);
    u_reg_host.rd(ADDR_DIAG, 16'h0001);
    ca(1'b0);
    smp(16'hFFEF, 16'h0050, 12'h000, 24'h0, 1'b0);
    u_reg_host.rd(ADDR_DIAG, 16'h0021);
    smp(16'hFFF0, 16'h0050, 12'h000, 24'h0, 1'b0);
    u_reg_host.rd(ADDR_DIAG, 16'h0001);
    {bhi, blo, thi, plim} <= {15'h0100, 15'h0010, 12'h010, 16'h0001};
    for (int i = 0; i < 9; i++)
    begin
      smp(16'hFFF8, T_BUS[i], T_TMP[i], T_PWR[i], 1'b0);
      u_reg_host.rd(ADDR_DIAG, T_EXP[i]);
    end
    smp(16'hFFF8, 16'h0050, 12'h000, 24'h0, 1'b0);
    wdiag(4'h8);
    smp(16'h0000, 16'h0050, 12'h000, 24'h0, 1'b0);
    smp(16'hFFF8, 16'h0050, 12'h000, 24'h0, 1'b0);
    u_reg_host.rd(ADDR_DIAG, 16'h8041);
    u_reg_host.rd(ADDR_DIAG, 16'h8001);
    pls(0);
    u_reg_host.rd(ADDR_DIAG, 16'h8003);
    u_reg_host.rd(ADDR_DIAG, 16'h8001);
    pls(0);
    pls(1);
    u_reg_host.rd(ADDR_DIAG, 16'h8001);
    pls(2);
    u_reg_host.rd(ADDR_DIAG, 16'h8201);
    u_reg_host.rd(ADDR_DIAG, 16'h8201);
    pls(1);
    u_reg_host.rd(ADDR_DIAG, 16'h8001);
    wdiag(4'hC);
    pls(0);
    ca(1'b1);
    u_reg_host.rd(ADDR_DIAG, 16'hC003);
    ca(1'b0);
    wdiag(4'h2);
    smp(16'h0000, 16'h0050, 12'h000, 24'h0, 1'b0);
    u_reg_host.rd(ADDR_DIAG, 16'h2001);
    smp(16'h0000, 16'h0050, 12'h000, 24'h0, 1'b1);
    u_reg_host.rd(ADDR_DIAG, 16'h2041);
    wdiag(4'h3);
    inv = 1'b1;
    ca(1'b1);
    smp(16'hFFF8, 16'h0050, 12'h000, 24'h0, 1'b1);
    ca(1'b0);
    // held as a level from here on, like a persistent checksum fault
    @(posedge clock_i);
    trim_err <= 1'b1;
    u_reg_host.rd(ADDR_DIAG, 16'h3000);
    repeat (2) @(posedge clock_i);
    end_sim();
  end
endmodule
